/* src/stmr_cfg.svh */
`ifndef STMR_CFG_SVH
`define STMR_CFG_SVH
`define STMR_OFF_CNT_LO 8'h00
`define STMR_OFF_CNT_HI 8'h04
`define STMR_OFF_CMPA_LO 8'h08
`define STMR_OFF_CMPA_HI 8'h0c
`define STMR_OFF_CTRL0 8'h10
`define STMR_OFF_CTRL1 8'h14
`define STMR_OFF_FLAGS 8'h18
`define STMR_CTRL0_ON 3
`define STMR_CTRL1_CCLR 0
`define STMR_CTRL1_DPX 1
`define STMR_CTRL1_POL 2
`define STMR_CTRL1_OC 3
`define STMR_CTRL1_IO_LSB 4
`define STMR_CTRL1_MODE_LSB 6
`define STMR_RST_BYTE 8'h00
`define STMR_RESP_OKAY 2'b00
`define STMR_RESP_SLVERR 2'b10
`endif

/* src/stmr_pkg.sv */
package stmr_pkg;
   typedef enum logic [1:0]
   {
      STMR_MODE_CMP = 2'b00,
      STMR_MODE_CAP = 2'b01,
      STMR_MODE_PWM = 2'b10,
      STMR_MODE_TMR = 2'b11
   } stmr_mode_t;
endpackage

/* src/stmr_timer.sv */
`timescale 1ns/1ps
`include "stmr_cfg.svh"
// How it works
// - Counter bits 7..0 read back as a read-only byte, reset zero.
// - Counter bits 9..8 in high byte bits 1..0, rest reads zero.
// - Compare-A low eight bits held in a read/write byte, reset zero.
// - Compare-A bits 9..8 in high byte bits 1..0, upper bits zero.
// - Mode field 00 selects compare match output mode.
// - Clear source low: clear on period match or overflow; both flags raise.
// - Clear source high: clear on compare-A match; only A flag raises.
// - Compare mode pin changes only on compare-A match flag.
// - Pin action sets high, low or toggles on match; zero does nothing.
// - Counter-on rising edge loads pin with the initial level bit.
// - Mode 11 behaves as compare mode but leaves pin unused.
// - PWM mode ignores clear-source select; period comparator clears counter.
// - Swap bit chooses which comparator sets period and which duty.
// - Swap low: period is 128 ticks times code, code zero gives 1024.
// - Swap high: period from compare-A, duty 128 times code, zero 1024.
// - Duty equal or above period gives continuously active output.
// - PWM mode raises each flag on its own comparator match.
// - PWM pin actions 00, 01 force inactive or active; counter runs.
// - Initial level picks PWM active level; invert bit flips the pin.
// - Period value compares against top three bits of count plus one; lower seven bits must be zero.
// - Counter clears on counter-on rising edge, holds when turned off.
module stmr_timer #(
   parameter int CNT_W = 10
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic tick,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic pin_out,
   output logic pin_oe
);
   // Elaboration refuses widths the fixed byte map cannot serve
   if (CNT_W != 10)
   begin : g_cnt_w_check
      $error("stmr_timer supports only a 10-bit counter");
   end

   logic [9:0] cnt_reg;
   logic [9:0] cmpa_reg;
   logic [7:0] ctrl0_reg;
   logic [7:0] ctrl1_reg;
   logic flag_a_reg;
   logic flag_p_reg;
   logic on_d_reg;
   logic pin_reg;
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;

   logic on_bit;
   logic on_rise;
   logic [2:0] per_val;
   logic [1:0] io_sel;
   stmr_pkg::stmr_mode_t mode;
   logic match_a;
   logic match_p;
   logic overflow;
   logic clr_cnt;
   logic set_a;
   logic set_p;
   logic wr_go;
   logic clr_flag_a;
   logic clr_flag_p;
   logic pwm_act;
   logic [9:0] duty_lim;
   logic [10:0] per_len;
   logic [9:0] cnt_inc;

   assign on_bit = ctrl0_reg[`STMR_CTRL0_ON];
   assign on_rise = on_bit & ~on_d_reg;
   assign per_val = ctrl0_reg[2:0];
   assign io_sel = ctrl1_reg[`STMR_CTRL1_IO_LSB +: 2];
   assign mode = stmr_pkg::stmr_mode_t'(ctrl1_reg[`STMR_CTRL1_MODE_LSB +: 2]);
   assign overflow = (cnt_reg == 10'h3ff);
   // Match on the count being reached, so a clear gives an exact period
   assign cnt_inc = cnt_reg + 10'h001;
   assign match_a = (cnt_inc == cmpa_reg);
   assign match_p = (per_val != 3'h0) && (cnt_inc[9:7] == per_val) && (cnt_inc[6:0] == 7'h00);

   always_comb
   begin
      clr_cnt = 1'b0;
      set_a = 1'b0;
      set_p = 1'b0;
      if (on_bit && tick)
      begin
         unique case (mode)
            stmr_pkg::STMR_MODE_PWM:
            begin
               if (ctrl1_reg[`STMR_CTRL1_DPX])
                  clr_cnt = match_a;
               else
                  clr_cnt = match_p | (per_val == 3'h0 && overflow);
               set_a = match_a;
               set_p = match_p;
            end
            stmr_pkg::STMR_MODE_CAP:
            begin
               clr_cnt = 1'b0;
            end
            default:
            begin
               if (ctrl1_reg[`STMR_CTRL1_CCLR])
               begin
                  clr_cnt = match_a;
                  set_a = match_a;
               end
               else
               begin
                  clr_cnt = match_p | (per_val == 3'h0 && overflow);
                  set_a = match_a;
                  set_p = match_p;
               end
            end
         endcase
      end
   end

   // Counter runs in period lengths; duty is compared against the count
   always_comb
   begin
      per_len = (per_val == 3'h0) ? 11'h400 : {1'b0, per_val, 7'h00};
      duty_lim = cmpa_reg;
      pwm_act = 1'b0;
      if (ctrl1_reg[`STMR_CTRL1_DPX])
      begin
         if (per_len >= {1'b0, cmpa_reg})
            pwm_act = 1'b1;
         else
            pwm_act = ({1'b0, cnt_reg} < per_len);
      end
      else
      begin
         if ({1'b0, duty_lim} >= per_len)
            pwm_act = 1'b1;
         else
            pwm_act = (cnt_reg < duty_lim);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         cnt_reg <= 10'h000;
      else if (clk_en)
      begin
         if (on_rise)
            cnt_reg <= 10'h000;
         else if (on_bit && tick)
            cnt_reg <= clr_cnt ? 10'h000 : cnt_reg + 10'h001;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         on_d_reg <= 1'b0;
      else if (clk_en)
         on_d_reg <= on_bit;
   end

   // Set beats clear so a match in the clearing cycle survives
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_a_reg <= 1'b0;
         flag_p_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         flag_a_reg <= set_a | (flag_a_reg & ~clr_flag_a);
         flag_p_reg <= set_p | (flag_p_reg & ~clr_flag_p);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         pin_reg <= 1'b0;
      else if (clk_en)
      begin
         if (on_rise)
            pin_reg <= ctrl1_reg[`STMR_CTRL1_OC];
         else if (mode == stmr_pkg::STMR_MODE_CMP && set_a)
         begin
            unique case (io_sel)
               2'b00: pin_reg <= pin_reg;
               2'b01: pin_reg <= 1'b0;
               2'b10: pin_reg <= 1'b1;
               2'b11: pin_reg <= ~pin_reg;
            endcase
         end
      end
   end

   // Output pin; invert applies to every driven mode
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end
      else if (clk_en)
      begin
         unique case (mode)
            stmr_pkg::STMR_MODE_PWM:
            begin
               pin_oe <= 1'b1;
               unique case (io_sel)
                  2'b00: pin_out <= ~ctrl1_reg[`STMR_CTRL1_OC] ^ ctrl1_reg[`STMR_CTRL1_POL];
                  2'b01: pin_out <= ctrl1_reg[`STMR_CTRL1_OC] ^ ctrl1_reg[`STMR_CTRL1_POL];
                  default: pin_out <= ~(pwm_act ^ ctrl1_reg[`STMR_CTRL1_OC])
                                      ^ ctrl1_reg[`STMR_CTRL1_POL];
               endcase
            end
            stmr_pkg::STMR_MODE_CMP:
            begin
               pin_oe <= 1'b1;
               pin_out <= pin_reg ^ ctrl1_reg[`STMR_CTRL1_POL];
            end
            default:
            begin
               pin_oe <= 1'b0;
               pin_out <= 1'b0;
            end
         endcase
      end
   end

   // AXI4-Lite write: address and data caught independently
   assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   assign clr_flag_a = wr_go && aw_addr_reg == `STMR_OFF_FLAGS && w_strb_reg[0] && w_data_reg[0];
   assign clr_flag_p = wr_go && aw_addr_reg == `STMR_OFF_FLAGS && w_strb_reg[0] && w_data_reg[1];

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `STMR_RESP_OKAY;
      end
      else if (clk_en)
      begin
         s_axi_awready <= !aw_hold_reg && !s_axi_awready;
         s_axi_wready <= !w_hold_reg && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_reg > `STMR_OFF_FLAGS) ? `STMR_RESP_SLVERR : `STMR_RESP_OKAY;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Control writes; counter bytes are read-only and ignore writes
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmpa_reg <= 10'h000;
         ctrl0_reg <= `STMR_RST_BYTE;
         ctrl1_reg <= `STMR_RST_BYTE;
      end
      else if (clk_en && wr_go && w_strb_reg[0])
      begin
         unique case (aw_addr_reg)
            `STMR_OFF_CMPA_LO: cmpa_reg[7:0] <= w_data_reg[7:0];
            `STMR_OFF_CMPA_HI: cmpa_reg[9:8] <= w_data_reg[1:0];
            `STMR_OFF_CTRL0: ctrl0_reg <= w_data_reg[7:0];
            `STMR_OFF_CTRL1: ctrl1_reg <= w_data_reg[7:0];
            default: ;
         endcase
      end
   end

   // AXI4-Lite read, one word per address
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `STMR_RESP_OKAY;
      end
      else if (clk_en)
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `STMR_RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
               `STMR_OFF_CNT_LO: s_axi_rdata <= {24'h000000, cnt_reg[7:0]};
               `STMR_OFF_CNT_HI: s_axi_rdata <= {30'h0, cnt_reg[9:8]};
               `STMR_OFF_CMPA_LO: s_axi_rdata <= {24'h000000, cmpa_reg[7:0]};
               `STMR_OFF_CMPA_HI: s_axi_rdata <= {30'h0, cmpa_reg[9:8]};
               `STMR_OFF_CTRL0: s_axi_rdata <= {24'h000000, ctrl0_reg};
               `STMR_OFF_CTRL1: s_axi_rdata <= {24'h000000, ctrl1_reg};
               `STMR_OFF_FLAGS: s_axi_rdata <= {30'h0, flag_p_reg, flag_a_reg};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `STMR_RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   a_cnt_on_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && on_rise) |=> (cnt_reg == 10'h000))
      else $error("counter not cleared on enable");
   a_pin_init: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && on_rise) |=> (pin_reg == $past(ctrl1_reg[`STMR_CTRL1_OC])))
      else $error("pin not loaded with initial level");
   a_cclr_no_pflag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (mode != stmr_pkg::STMR_MODE_PWM && ctrl1_reg[`STMR_CTRL1_CCLR]) |-> !set_p)
      else $error("period flag raised with clear source high");
   a_pin_only_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !on_rise && !set_a) |=> $stable(pin_reg))
      else $error("pin moved without compare-A match");
   a_pmatch_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !on_rise && set_p && mode == stmr_pkg::STMR_MODE_CMP) |=> cnt_reg == 10'h000)
      else $error("period match did not clear counter");
   a_tmr_no_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && mode == stmr_pkg::STMR_MODE_TMR) |=> !pin_oe)
      else $error("pin driven in timer mode");
   a_rd_cnt_lo: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr == `STMR_OFF_CNT_LO)
      |=> s_axi_rdata == {24'h000000, $past(cnt_reg[7:0])})
      else $error("counter low byte readback wrong");
   a_pwm_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clk_en && set_a) |=> flag_a_reg)
      else $error("compare-A flag not set");
endmodule

/* tb/stmr_test.sv */
`timescale 1ns/1ps
`include "stmr_cfg.svh"
module standard_10bit_timer_compare_pwm_test;
   typedef struct {logic [7:0] a; logic wr; logic [31:0] d; logic [31:0] e; logic [1:0] r;} stmr_row_t;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic tick = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int errors = 0;
   int n_tests = 0;
   stmr_row_t rows[10] = '{
      '{8'h00, 1'b0, 32'h0, 32'h0, 2'b00}, '{8'h04, 1'b0, 32'h0, 32'h0, 2'b00},
      '{8'h08, 1'b0, 32'h0, 32'h0, 2'b00}, '{8'h0c, 1'b0, 32'h0, 32'h0, 2'b00},
      '{8'h08, 1'b1, 32'hffffffa5, 32'ha5, 2'b00}, '{8'h0c, 1'b1, 32'hffffffff, 32'h3, 2'b00},
      '{8'h00, 1'b1, 32'h55, 32'h0, 2'b00}, '{8'h04, 1'b1, 32'hff, 32'h0, 2'b00},
      '{8'h1c, 1'b1, 32'h1, 32'h0, 2'b10}, '{8'h08, 1'b0, 32'h0, 32'ha5, 2'b00}};

   always #5 clk_sys = ~clk_sys;

   stmr_timer DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .tick(tick),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pin_out(pin_out), .pin_oe(pin_oe));

   task automatic finish_test();
      $display("Checks %0d, errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      chk32(nm, {31'h0, e}, {31'h0, g});
   endtask

   // Master holds each channel until its own handshake edge
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      r = 2'bxx;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Only the watchdog ends a wait for the slave
      forever
      begin
         @(posedge clk_sys);
         if (awvalid && awready === 1'b1)
            awvalid <= 1'b0;
         if (wvalid && wready === 1'b1)
            wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
      @(posedge clk_sys);
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      r = 2'bxx;
      d = 32'hx;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge clk_sys);
         if (arvalid && arready === 1'b1)
            arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
      @(posedge clk_sys);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axw(a, d, r);
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axr(a, d, r);
      chk32(nm, e, d);
   endtask

   // Ticks only move the counter; settle time lets the registered pin land
   task automatic tk(input int n);
      repeat (n)
      begin
         tick <= 1'b1;
         @(posedge clk_sys);
      end
      tick <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic pwm_hi(input int n, output int h);
      h = 0;
      repeat (n)
      begin
         tick <= 1'b1;
         @(posedge clk_sys);
         if (pin_out === 1'b1)
            h++;
      end
      tick <= 1'b0;
      @(posedge clk_sys);
   endtask

   initial
   begin
      repeat (50000) @(posedge clk_sys);
      errors++;
      finish_test();
   end

   initial
   begin
      logic [31:0] d, d2;
      logic [1:0] r;
      int h;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      for (int k = 0; k < 10; k++)
      begin
         if (rows[k].wr)
         begin
            axw(rows[k].a, rows[k].d, r);
            chk32("bresp", {30'h0, rows[k].r}, {30'h0, r});
         end
         axr(rows[k].a, d, r);
         chk32("rresp", {30'h0, rows[k].r}, {30'h0, r});
         if (rows[k].r === 2'b00)
            chk32("rdata", rows[k].e, d);
      end
      // Compare mode, clear on A, period code below compare-A
      wr(`STMR_OFF_CMPA_LO, 32'hc8);
      wr(`STMR_OFF_CMPA_HI, 32'h0);
      wr(`STMR_OFF_CTRL1, 32'h31);
      wr(`STMR_OFF_CTRL0, 32'h09);
      chk1("pin_oe", 1'b1, pin_oe);
      chk1("pin init", 1'b0, pin_out);
      tk(199);
      rdchk("flags", `STMR_OFF_FLAGS, 32'h0);
      chk1("pin early", 1'b0, pin_out);
      tk(1);
      rdchk("flags", `STMR_OFF_FLAGS, 32'h1);
      chk1("pin toggle", 1'b1, pin_out);
      wr(`STMR_OFF_FLAGS, 32'h3);
      rdchk("flags clr", `STMR_OFF_FLAGS, 32'h0);
      // Off holds the count, on restarts from zero
      tk(7);
      wr(`STMR_OFF_CTRL0, 32'h01);
      axr(`STMR_OFF_CNT_LO, d, r);
      tk(10);
      axr(`STMR_OFF_CNT_LO, d2, r);
      chk32("cnt hold", d, d2);
      wr(`STMR_OFF_CMPA_LO, 32'h05);
      wr(`STMR_OFF_CTRL1, 32'h28);
      wr(`STMR_OFF_CTRL0, 32'h09);
      rdchk("cnt on", `STMR_OFF_CNT_LO, 32'h0);
      chk1("pin init hi", 1'b1, pin_out);
      wr(`STMR_OFF_CTRL0, 32'h01);
      wr(`STMR_OFF_CTRL1, 32'h20);
      wr(`STMR_OFF_CTRL0, 32'h09);
      tk(5);
      rdchk("flags", `STMR_OFF_FLAGS, 32'h1);
      chk1("pin high", 1'b1, pin_out);
      tk(123);
      rdchk("flags", `STMR_OFF_FLAGS, 32'h3);
      chk1("pin kept", 1'b1, pin_out);
      axr(`STMR_OFF_CNT_LO, d, r);
      chk1("cnt cleared", 1'b1, d < 32'h80);
      wr(`STMR_OFF_CTRL1, 32'hc0);
      chk1("pin_oe tmr", 1'b0, pin_oe);
      // PWM, duty above period stays active
      wr(`STMR_OFF_CTRL0, 32'h01);
      wr(`STMR_OFF_CMPA_LO, 32'hc8);
      wr(`STMR_OFF_CTRL1, 32'ha9);
      wr(`STMR_OFF_FLAGS, 32'h3);
      wr(`STMR_OFF_CTRL0, 32'h09);
      tk(20);
      pwm_hi(300, h);
      chk32("full duty", 32'd300, h);
      rdchk("pwm flags", `STMR_OFF_FLAGS, 32'h2);
      wr(`STMR_OFF_CMPA_LO, 32'h40);
      tk(130);
      pwm_hi(256, h);
      chk32("duty 64", 32'd128, h);
      wr(`STMR_OFF_CMPA_HI, 32'h1);
      wr(`STMR_OFF_CMPA_LO, 32'h2c);
      wr(`STMR_OFF_CTRL1, 32'haa);
      tk(600);
      pwm_hi(600, h);
      chk32("swap duty", 32'd256, h);
      wr(`STMR_OFF_CTRL1, 32'h88);
      chk1("forced off", 1'b0, pin_out);
      wr(`STMR_OFF_CTRL1, 32'h98);
      chk1("forced on", 1'b1, pin_out);
      wr(`STMR_OFF_CTRL1, 32'h8c);
      chk1("inverted", 1'b1, pin_out);
      axr(`STMR_OFF_CNT_LO, d, r);
      tk(3);
      axr(`STMR_OFF_CNT_LO, d2, r);
      chk1("still runs", 1'b1, d2 !== d);
      // Mid-run reset returns every register to zero
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      rdchk("rst cnt lo", `STMR_OFF_CNT_LO, 32'h0);
      rdchk("rst cmpa lo", `STMR_OFF_CMPA_LO, 32'h0);
      rdchk("rst cmpa hi", `STMR_OFF_CMPA_HI, 32'h0);
      chk1("rst pin_oe", 1'b1, pin_oe);
      // Low enable freezes the counter
      wr(`STMR_OFF_CMPA_LO, 32'h40);
      wr(`STMR_OFF_CTRL0, 32'h09);
      tk(4);
      clk_en <= 1'b0;
      tk(6);
      clk_en <= 1'b1;
      rdchk("frozen cnt", `STMR_OFF_CNT_LO, 32'h4);
      finish_test();
   end
endmodule
